// [core/mrb_ctrl.sv]
// Transmit retry and backoff control with receive pad and FCS stripping.
`timescale 1ns/1ps
`include "mrb_consts.svh"

module mrb_ctrl
   import mrb_pkg::*;
(
   // Clock and asynchronous reset.
   input wire logic ref_clk,
   input wire logic rst_n,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Transmit queue side.
   input wire logic tx_req,
   output logic tx_go,
   output logic tx_done,
   output logic tx_retry_err,
   // Media side reports of the attempt in flight.
   input wire logic tx_end,
   input wire logic phy_col,
   // Received byte stream in.
   input wire logic rx_valid,
   input wire logic rx_sof,
   input wire logic rx_eof,
   input wire logic [7:0] rx_data,
   // Received byte stream to the host.
   output logic rxo_valid,
   output logic rxo_sof,
   output logic rxo_eof,
   output logic [7:0] rxo_data,
   // Interrupt.
   output logic irq
);

   // Number of LFSR bits allowed by the backoff-limit selector.
   function automatic logic [3:0] lim_bits(input logic [1:0] sel);
      logic [3:0] n;
      n = 4'h0;
      unique case (mrb_bolim_t'(sel))
         BL_10: n = 4'ha;
         BL_8: n = 4'h8;
         BL_4: n = 4'h4;
         BL_1: n = 4'h1;
      endcase
      return n;
   endfunction

   // Mask of the low n bits of the random source.
   function automatic logic [9:0] low_mask(input logic [3:0] n);
      logic [9:0] m;
      m = 10'h000;
      for (int i = 0; i < 10; i++)
         m[i] = (4'(i) < n);
      return m;
   endfunction

   // Reset release through two flip-flops.
   logic rst_a_r;
   logic rst_sn;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_a_r <= 1'b0;
         rst_sn <= 1'b0;
      end
      else
      begin
         rst_a_r <= 1'b1;
         rst_sn <= rst_a_r;
      end
   end

   // Collision pin synchroniser; only the second stage is used.
   logic col_a_r;
   logic col_s_r;

   always_ff @(posedge ref_clk or negedge rst_sn)
   begin
      if (!rst_sn)
      begin
         col_a_r <= 1'b0;
         col_s_r <= 1'b0;
      end
      else
      begin
         col_a_r <= phy_col;
         col_s_r <= col_a_r;
      end
   end

   // Registers.
   logic [31:0] ctrl_r;
   logic [`MRB_IRQ_W-1:0] ist_r;
   logic [`MRB_IRQ_W-1:0] ist_nxt;
   logic [`MRB_IRQ_W-1:0] imask_r;
   logic [`MRB_IRQ_W-1:0] ev;
   logic single_attempt_ctl;
   logic rx_pad_strip_en;
   logic [1:0] backoff_limit_sel;

   assign single_attempt_ctl = ctrl_r[`MRB_SINGLE_BIT];
   assign rx_pad_strip_en = ctrl_r[`MRB_PAD_BIT];
   assign backoff_limit_sel = ctrl_r[`MRB_BOLIM_HI:`MRB_BOLIM_LO];

   // Only the documented control bits are writable; the rest read zero.
   always_ff @(posedge ref_clk or negedge rst_sn)
   begin
      if (!rst_sn)
         ctrl_r <= `MRB_CTRL_RST;
      else if (reg_wr && reg_addr == `MRB_ADDR_CTRL)
      begin
         ctrl_r <= 32'h0000_0000;
         ctrl_r[`MRB_SINGLE_BIT] <= reg_wdata[`MRB_SINGLE_BIT];
         ctrl_r[`MRB_PAD_BIT] <= reg_wdata[`MRB_PAD_BIT];
         ctrl_r[`MRB_BOLIM_HI:`MRB_BOLIM_LO] <=
            reg_wdata[`MRB_BOLIM_HI:`MRB_BOLIM_LO];
      end
   end

   // Interrupt mask register.
   always_ff @(posedge ref_clk or negedge rst_sn)
   begin
      if (!rst_sn)
         imask_r <= `MRB_MASK_RST;
      else if (reg_wr && reg_addr == `MRB_ADDR_IRQ_MASK)
         imask_r <= reg_wdata[`MRB_IRQ_W-1:0];
   end

   // Sticky status: a read clears it, but an event in that same cycle wins.
   assign ist_nxt = ((reg_rd && reg_addr == `MRB_ADDR_IRQ_ST) ?
      {`MRB_IRQ_W{1'b0}} : ist_r) | ev;

   always_ff @(posedge ref_clk or negedge rst_sn)
   begin
      if (!rst_sn)
      begin
         ist_r <= {`MRB_IRQ_W{1'b0}};
         irq <= 1'b0;
      end
      else
      begin
         ist_r <= ist_nxt;
         irq <= |(ist_nxt & imask_r);
      end
   end

   // Random source.
   logic [`MRB_LFSR_W-1:0] rnd;

   mrb_lfsr u_lfsr
   (
      .clk(ref_clk),
      .rst_n(rst_sn),
      .value(rnd)
   );

   // Transmit retry state.
   mrb_tx_st_t st_r;
   logic [4:0] att_r;
   logic [9:0] bo_r;
   logic [10:0] slot_cnt_r;
   logic slot_tick;
   logic [3:0] k_val;
   logic [3:0] use_bits;
   logic coll;
   logic give_up;

   // The exponent follows the retries so far, never above ten.
   assign k_val = (att_r > 5'(`MRB_K_MAX)) ? 4'(`MRB_K_MAX) : att_r[3:0];
   // The selector may only shorten the draw, never lengthen it.
   assign use_bits = (lim_bits(backoff_limit_sel) < k_val) ?
      lim_bits(backoff_limit_sel) : k_val;
   assign coll = (st_r == ST_SEND) && col_s_r;
   assign give_up = single_attempt_ctl ||
      (att_r == 5'(`MRB_MAX_ATT));

   // Slot divider restarts with each backoff so the first slot is whole.
   always_ff @(posedge ref_clk or negedge rst_sn)
   begin
      if (!rst_sn)
         slot_cnt_r <= 11'h000;
      else if (st_r != ST_WAIT || slot_tick)
         slot_cnt_r <= 11'h000;
      else
         slot_cnt_r <= slot_cnt_r + 11'h001;
   end

   assign slot_tick = (slot_cnt_r == 11'(`MRB_SLOT_CYC - 1));

   // Attempt sequencing: send, and on collision back off or drop.
   always_ff @(posedge ref_clk or negedge rst_sn)
   begin
      if (!rst_sn)
      begin
         st_r <= ST_IDLE;
         att_r <= 5'h00;
         bo_r <= 10'h000;
         tx_go <= 1'b0;
         tx_done <= 1'b0;
         tx_retry_err <= 1'b0;
      end
      else
      begin
         tx_go <= 1'b0;
         tx_done <= 1'b0;
         tx_retry_err <= 1'b0;
         unique case (st_r)
            ST_IDLE:
            begin
               if (tx_req)
               begin
                  st_r <= ST_SEND;
                  att_r <= 5'h01;
                  tx_go <= 1'b1;
               end
            end
            ST_SEND:
            begin
               // A collision beats a clean end reported in the same cycle.
               if (col_s_r)
               begin
                  if (give_up)
                  begin
                     st_r <= ST_IDLE;
                     att_r <= 5'h00;
                     tx_done <= 1'b1;
                     tx_retry_err <= 1'b1;
                  end
                  else
                  begin
                     st_r <= ST_WAIT;
                     bo_r <= rnd[9:0] & low_mask(use_bits);
                  end
               end
               else if (tx_end)
               begin
                  st_r <= ST_IDLE;
                  att_r <= 5'h00;
                  tx_done <= 1'b1;
               end
            end
            ST_WAIT:
            begin
               if (bo_r == 10'h000)
               begin
                  st_r <= ST_SEND;
                  att_r <= att_r + 5'h01;
                  tx_go <= 1'b1;
               end
               else if (slot_tick)
                  bo_r <= bo_r - 10'h001;
            end
         endcase
      end
   end

   // Receive pad stripping; the length field sits at bytes 12 and 13.
   logic [10:0] rx_cnt_r;
   logic [10:0] idx;
   logic [7:0] len_hi_r;
   logic [15:0] len_now;
   logic strip_r;
   logic strip_now;
   logic [15:0] keep_r;
   logic [15:0] keep_now;
   logic dead_r;
   logic keep_byte;
   logic last_kept;
   logic pad_ev;

   assign idx = rx_sof ? 11'h000 : rx_cnt_r;
   assign len_now = {len_hi_r, rx_data};

   // Decide at the low length byte; nothing earlier is pad.
   always_comb
   begin
      strip_now = strip_r;
      keep_now = keep_r;
      if (idx == 11'(`MRB_LEN_LO_IDX))
      begin
         strip_now = rx_pad_strip_en &&
            (len_now < 16'(`MRB_MIN_LEN));
         keep_now = len_now + 16'(`MRB_HDR_LEN);
      end
   end

   // Pad and FCS go together: everything past the payload is dropped.
   assign keep_byte = !dead_r &&
      (!strip_now || {5'h00, idx} < keep_now);
   assign last_kept = rx_eof ||
      (strip_now && {5'h00, idx} == keep_now - 16'h0001);
   assign pad_ev = rx_valid && !dead_r && strip_now && !rx_eof &&
      ({5'h00, idx} == keep_now - 16'h0001);

   // Per-frame byte position and strip decision.
   always_ff @(posedge ref_clk or negedge rst_sn)
   begin
      if (!rst_sn)
      begin
         rx_cnt_r <= 11'h000;
         len_hi_r <= 8'h00;
         strip_r <= 1'b0;
         keep_r <= 16'h0000;
         dead_r <= 1'b0;
      end
      else if (rx_valid)
      begin
         rx_cnt_r <= idx + 11'h001;
         if (idx == 11'(`MRB_LEN_HI_IDX))
            len_hi_r <= rx_data;
         strip_r <= strip_now;
         keep_r <= keep_now;
         if (rx_sof)
            dead_r <= 1'b0;
         if (keep_byte && last_kept && !rx_eof)
            dead_r <= 1'b1;
         if (rx_eof)
         begin
            strip_r <= 1'b0;
            dead_r <= 1'b0;
         end
      end
   end

   // Host-side stream, one cycle behind the input.
   always_ff @(posedge ref_clk or negedge rst_sn)
   begin
      if (!rst_sn)
      begin
         rxo_valid <= 1'b0;
         rxo_sof <= 1'b0;
         rxo_eof <= 1'b0;
         rxo_data <= 8'h00;
      end
      else
      begin
         rxo_valid <= rx_valid && keep_byte;
         rxo_sof <= rx_valid && keep_byte && rx_sof;
         rxo_eof <= rx_valid && keep_byte && last_kept;
         rxo_data <= rx_data;
      end
   end

   // Events that feed the sticky status.
   always_comb
   begin
      ev = {`MRB_IRQ_W{1'b0}};
      ev[`MRB_IRQ_TX_OK] = (st_r == ST_SEND) && !col_s_r && tx_end;
      ev[`MRB_IRQ_RETRY_ERR] = coll && give_up;
      ev[`MRB_IRQ_PAD_STRIP] = pad_ev;
      ev[`MRB_IRQ_COLL] = coll;
   end

   // Read data stands in the cycle after the strobe only.
   always_ff @(posedge ref_clk or negedge rst_sn)
   begin
      if (!rst_sn)
         reg_rdata <= 32'h0000_0000;
      else if (reg_rd)
      begin
         unique case (reg_addr)
            `MRB_ADDR_CTRL: reg_rdata <= ctrl_r;
            `MRB_ADDR_IRQ_ST: reg_rdata <= {28'h000_0000, ist_r};
            `MRB_ADDR_IRQ_MASK: reg_rdata <= {28'h000_0000, imask_r};
            `MRB_ADDR_STATE:
               reg_rdata <= {13'h0000, bo_r, 1'b0, att_r, st_r};
            default: reg_rdata <= 32'h0000_0000;
         endcase
      end
      else
         reg_rdata <= 32'h0000_0000;
   end

endmodule

// [core/mrb_consts.svh]
// Offsets, field positions, reset values and timing counts of the retry block.
// How it works
// - A set single-attempt bit at position 10 allows one attempt per frame.
// - In single-attempt mode a collision drops the frame with a retry error.
// - Otherwise a frame gets up to 16 attempts, erroring only after the last.
// - A set pad-strip bit at position 8 removes pad when length is below 46.
// - A frame whose pad is removed also loses its frame check sequence.
// - Frames with a length field of 46 or more pass whole, FCS kept.
// - With pad-strip clear every received frame passes whole.
// - After a collision the MAC waits r slot times, r below 2**K; sel is 7:6.
// - K is the frame's current retry count, capped at 10.
// - The random value comes from a free-running 20-bit LFSR.
// - The low K LFSR bits load a backoff counter that counts slots to zero.
// - The backoff-limit selector caps the number of LFSR bits used at 10, 8, 4 or 1, never raising it above K.
`ifndef MRB_CONSTS_SVH
`define MRB_CONSTS_SVH

// Register byte addresses.
`define MRB_ADDR_CTRL 8'h00
`define MRB_ADDR_IRQ_ST 8'h04
`define MRB_ADDR_IRQ_MASK 8'h08
`define MRB_ADDR_STATE 8'h0c

// Control register field positions.
`define MRB_SINGLE_BIT 10
`define MRB_PAD_BIT 8
`define MRB_BOLIM_HI 7
`define MRB_BOLIM_LO 6

// Interrupt status bit positions.
`define MRB_IRQ_TX_OK 0
`define MRB_IRQ_RETRY_ERR 1
`define MRB_IRQ_PAD_STRIP 2
`define MRB_IRQ_COLL 3
`define MRB_IRQ_W 4

// Reset values.
`define MRB_CTRL_RST 32'h0000_0000
`define MRB_MASK_RST 4'h0

// Retry, backoff and frame figures.
`define MRB_LFSR_W 20
`define MRB_LFSR_SEED 20'h0_0001
`define MRB_K_MAX 10
`define MRB_MAX_ATT 16
`define MRB_MIN_LEN 46
`define MRB_HDR_LEN 14
`define MRB_LEN_HI_IDX 12
`define MRB_LEN_LO_IDX 13

// Slot time of 512 bit times at 10 Mb/s, and the clock period.
`define MRB_SLOT_NS 51200
`define MRB_CLK_NS 50
`define MRB_SLOT_CYC (`MRB_SLOT_NS / `MRB_CLK_NS)

`endif

// [core/mrb_pkg.sv]
// Types shared by the retry, backoff and pad-strip block.
package mrb_pkg;

   // Transmit retry state machine, one-hot.
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_SEND = 3'b010,
      ST_WAIT = 3'b100
   } mrb_tx_st_t;

   // Backoff-limit selector encodings.
   typedef enum logic [1:0]
   {
      BL_10 = 2'b00,
      BL_8 = 2'b01,
      BL_4 = 2'b10,
      BL_1 = 2'b11
   } mrb_bolim_t;

endpackage

// [core/mrb_lfsr.sv]
// Free-running 20-bit pseudo-random source for the collision backoff.
`timescale 1ns/1ps
`include "mrb_consts.svh"

module mrb_lfsr
   import mrb_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Current value.
   output logic [`MRB_LFSR_W-1:0] value
);

   logic [`MRB_LFSR_W-1:0] lfsr_r;
   logic fb;

   // Taps 20 and 17 give a maximal sequence; the all-zero lock is avoided
   // by the nonzero seed.
   assign fb = lfsr_r[19] ^ lfsr_r[16];

   // Shifts every cycle so that the draw depends on collision timing.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         lfsr_r <= `MRB_LFSR_SEED;
      else
         lfsr_r <= {lfsr_r[`MRB_LFSR_W-2:0], fb};
   end

   assign value = lfsr_r;

endmodule

// [tb/mrb_ctrl_sva.sv]
// Checker for the retry, backoff and pad-strip block.
`timescale 1ns/1ps
`include "mrb_consts.svh"

module mrb_ctrl_sva
   import mrb_pkg::*;
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_n,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // Transmit side.
   input wire logic tx_go,
   input wire logic tx_done,
   input wire logic tx_retry_err,
   // Receive streams.
   input wire logic rx_valid,
   input wire logic rx_eof,
   input wire logic [7:0] rx_data,
   input wire logic rxo_valid,
   input wire logic rxo_eof,
   input wire logic [7:0] rxo_data
);
   logic single_r;
   logic pad_r;
   logic [1:0] sel_r;
   logic [4:0] go_r;
   logic [15:0] gap_r;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // Shadow of the control bits as written through the port.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         {single_r, pad_r, sel_r} <= 4'h0;
      else if (reg_wr && reg_addr == `MRB_ADDR_CTRL)
         {single_r, pad_r, sel_r} <= {reg_wdata[10], reg_wdata[8:6]};
   end

   // Attempts of this frame; the gap saturates so it never wraps.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         go_r <= 5'h00;
         gap_r <= 16'h0000;
      end
      else
      begin
         go_r <= tx_done ? 5'h00 : go_r + {4'h0, tx_go};
         gap_r <= tx_go ? 16'h0000 : gap_r + {15'h0, gap_r != 16'hffff};
      end
   end

   property p_ctrl_rd;
      reg_rd && reg_addr == `MRB_ADDR_CTRL |=>
         reg_rdata[10:6] == {single_r, 1'b0, pad_r, sel_r};
   endproperty
   a_ctrl_rd: assert property (p_ctrl_rd) else $error("ctrl read");
   property p_rx_pass;
      rxo_valid |-> $past(rx_valid) && rxo_data == $past(rx_data);
   endproperty
   a_rx_pass: assert property (p_rx_pass) else $error("rx data");
   property p_rx_whole;
      !pad_r |-> rxo_valid == $past(rx_valid) && rxo_eof == $past(rx_eof);
   endproperty
   a_rx_whole: assert property (p_rx_whole) else $error("rx whole");
   property p_single;
      single_r && tx_go |-> go_r == 5'h00;
   endproperty
   a_single: assert property (p_single) else $error("second try");
   property p_max_att;
      tx_go |-> go_r < 5'h10;
   endproperty
   a_max_att: assert property (p_max_att) else $error("too many");
   property p_err_last;
      tx_retry_err |-> go_r == (single_r ? 5'h01 : 5'h10);
   endproperty
   a_err_last: assert property (p_err_last) else $error("early err");
   property p_err_done;
      tx_retry_err |-> tx_done;
   endproperty
   a_err_done: assert property (p_err_done) else $error("err alone");
   property p_done_gap;
      tx_done |=> !tx_go;
   endproperty
   a_done_gap: assert property (p_done_gap) else $error("go at done");
   property p_gap;
      tx_go && go_r != 5'h00 && sel_r == 2'b11 |-> gap_r < 16'h044c;
   endproperty
   a_gap: assert property (p_gap) else $error("backoff long");

   c_err: cover property (tx_retry_err);
   c_ok: cover property (tx_done && !tx_retry_err);
   c_eof: cover property (rxo_eof && pad_r);
endmodule

bind mrb_ctrl mrb_ctrl_sva u_mrb_ctrl_sva (.ref_clk(ref_clk),
   .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .tx_go(tx_go), .tx_done(tx_done), .tx_retry_err(tx_retry_err),
   .rx_valid(rx_valid), .rx_eof(rx_eof), .rx_data(rx_data),
   .rxo_valid(rxo_valid), .rxo_eof(rxo_eof), .rxo_data(rxo_data));

// [tb/mrb_phy_model.sv]
// Model of the PHY and shared medium answering each attempt.
`timescale 1ns/1ps

module mrb_phy_model
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Attempt start, and whether the medium is busy.
   input wire logic tx_go,
   input wire logic col_on,
   // Media reports.
   output logic tx_end,
   output logic phy_col
);
   logic [3:0] age_r;

   // Age of the attempt; the collision lasts one cycle so that its
   // synchronised copy has gone before a retry that follows at once.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         age_r <= 4'h0;
      else if (tx_go)
         age_r <= 4'h1;
      else if (age_r != 4'h0 && age_r != 4'h8)
         age_r <= age_r + 4'h1;
      else
         age_r <= 4'h0;
   end

   assign tx_end = !col_on && age_r == 4'h6;
   assign phy_col = col_on && age_r == 4'h3;
endmodule

// [tb/mrb_ctrl_test.sv]
// Self-checking bench for the retry, backoff and pad-strip block.
`timescale 1ns/1ps
`include "mrb_consts.svh"

module mrb_ctrl_test;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic tx_req = 1'b0;
   logic col_on = 1'b0;
   logic rx_valid = 1'b0;
   logic rx_sof = 1'b0;
   logic rx_eof = 1'b0;
   logic [7:0] rx_data = 8'h00;
   logic [31:0] reg_rdata, rv;
   logic tx_go, tx_done, tx_retry_err, tx_end, phy_col;
   logic rxo_valid, rxo_sof, rxo_eof, irq;
   logic [7:0] rxo_data;
   int bad_count = 0;
   int checked = 0;
   int go_n = 0;
   int rx_n = 0;
   int eof_at = 0;
   int sof_at = 0;

   always #25 ref_clk = ~ref_clk;

   mrb_ctrl u_mrb_ctrl (.ref_clk(ref_clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_req(tx_req),
      .tx_go(tx_go), .tx_done(tx_done), .tx_retry_err(tx_retry_err),
      .tx_end(tx_end), .phy_col(phy_col), .rx_valid(rx_valid),
      .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_data(rx_data),
      .rxo_valid(rxo_valid), .rxo_sof(rxo_sof), .rxo_eof(rxo_eof),
      .rxo_data(rxo_data), .irq(irq));

   mrb_phy_model u_mrb_phy_model (.clk(ref_clk), .rst_n(rst_n),
      .tx_go(tx_go), .col_on(col_on), .tx_end(tx_end), .phy_col(phy_col));

   // Tally of attempts and delivered bytes, with the place of the end mark.
   always @(posedge ref_clk)
   begin
      go_n = go_n + tx_go;
      if (rxo_valid)
      begin
         rx_n = rx_n + 1;
         if (rxo_sof)
            sof_at = rx_n;
         if (rxo_eof)
            eof_at = rx_n;
      end
   end

   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      checked = checked + 1;
      if (got !== exp)
      begin
         bad_count = bad_count + 1;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe.
   task automatic rd(logic [7:0] a);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      rv = reg_rdata;
   endtask

   task automatic reg_case();
      rd(`MRB_ADDR_CTRL);
      chk("ctrl reset", `MRB_CTRL_RST, rv);
      rd(`MRB_ADDR_STATE);
      chk("state idle", 32'h0000_0001, rv);
      wr(`MRB_ADDR_CTRL, 32'hffff_ffff);
      rd(`MRB_ADDR_CTRL);
      chk("ctrl bits", 32'h0000_05c0, rv);
      rd(8'h10);
      chk("unmapped", 32'h0000_0000, rv);
      $display("registers done");
   endtask

   // One frame: mask m, medium busy or not, then counts and status.
   task automatic tx_case(logic [31:0] c, logic [3:0] m, logic col,
      int n, logic err, logic [31:0] st);
      int i;
      wr(`MRB_ADDR_CTRL, c);
      wr(`MRB_ADDR_IRQ_MASK, {28'h0, m});
      col_on <= col;
      go_n = 0;
      tx_req <= 1'b1;
      // One queued frame: the request is taken at the next edge only.
      @(posedge ref_clk);
      tx_req <= 1'b0;
      for (i = 0; i < 40000 && tx_done !== 1'b1; i++)
         @(negedge ref_clk);
      if (i == 40000)
      begin
         bad_count = bad_count + 1;
         conclude();
      end
      chk("retry error", {31'h0, err}, {31'h0, tx_retry_err});
      chk("attempts", n, go_n);
      repeat (3) @(posedge ref_clk);
      chk("irq", {31'h0, (st[3:0] & m) != 4'h0}, {31'h0, irq});
      rd(`MRB_ADDR_IRQ_ST);
      chk("status", st, rv);
      @(negedge ref_clk);
      chk("irq clear", 32'h0000_0000, {31'h0, irq});
      $display("transmit case done");
   endtask

   // One received frame; the length sits in bytes 12 and 13.
   task automatic rx_case(logic [31:0] c, int n, int len);
      int i;
      int e;
      e = (c[8] && len < 46) ? 14 + len : n;
      wr(`MRB_ADDR_CTRL, c);
      rx_n = 0;
      eof_at = 0;
      sof_at = 0;
      for (i = 0; i < n; i++)
      begin
         @(posedge ref_clk);
         rx_valid <= 1'b1;
         rx_sof <= i == 0;
         rx_eof <= i == n - 1;
         rx_data <= i == 12 ? 8'h00 : i == 13 ? len[7:0] : i[7:0];
      end
      @(posedge ref_clk);
      rx_valid <= 1'b0;
      rx_eof <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk("rx bytes", e, rx_n);
      chk("rx eof place", e, eof_at);
      chk("rx sof place", 1, sof_at);
      rd(`MRB_ADDR_IRQ_ST);
      chk("strip flag", {29'h0, e != n, 2'b00}, rv);
      $display("receive case done");
   endtask

   initial
   begin
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      reg_case();
      tx_case(32'h0000_0400, 4'hf, 1'b1, 1, 1'b1, 32'h0000_000a);
      tx_case(32'h0000_00c0, 4'h0, 1'b1, 16, 1'b1, 32'h0000_000a);
      tx_case(32'h0000_0000, 4'h1, 1'b0, 1, 1'b0, 32'h0000_0001);
      rx_case(32'h0000_0100, 20, 2);
      rx_case(32'h0000_0100, 64, 46);
      rx_case(32'h0000_0000, 20, 2);
      conclude();
   end
endmodule
